// File: core/cfi_defs.svh
// register offsets, field positions and reset values of the fifo interrupt block
`ifndef CFI_DEFS_SVH
`define CFI_DEFS_SVH
// ----------------------------------------------------------------------------
// byte offsets on the register bus
// ----------------------------------------------------------------------------
`define CFI_OFS_CTRL    5'h00
`define CFI_OFS_CFG     5'h04
`define CFI_OFS_EVT     5'h08
`define CFI_OFS_CLR     5'h0c
`define CFI_OFS_IEN     5'h10
// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define CFI_TX_IE_LSB   24
`define CFI_RX_IE_LSB   16
`define CFI_TX_IF_LSB   8
`define CFI_RX_IF_LSB   0
`define CFI_OVF_POS     3
`define CFI_DIR_POS     0
`define CFI_FLAG_MASK   32'h0000_070f
`define CFI_IMPL_MASK   32'h070f_070f
// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define CFI_TX_IE_RST   3'h0
`define CFI_RX_IE_RST   4'h0
`define CFI_OVF_RST     1'b0
`define CFI_DIR_RST     1'b0
`define CFI_WORD_RST    32'h0000_0000
`endif

// File: core/cfi_flag_eval.sv
// turns the live fifo occupancy into registered status flags
module cfi_flag_eval
  import cfi_pkg::*;
#(
  parameter int unsigned DEPTH = 32,
  parameter int unsigned LVL_W = 6
)
(
  input  wire logic sys_clk_i,
  input  wire logic arst_n_i,
  cfi_flag_if.eval  flg
);

  localparam logic [LVL_W-1:0] FULL = LVL_W'(DEPTH);
  localparam logic [LVL_W-1:0] HALF = LVL_W'(DEPTH / 2);

  cfi_flags_s next_flags;

  // ----------------------------------------------------------------------------
  // flag evaluation
  // ----------------------------------------------------------------------------
  // flags of the other direction are forced low here; the registered copy drops them one edge after a direction change
  always_comb
  begin
    next_flags = '0;
    if (flg.transmit)
    begin
      next_flags.tx_space   = (flg.level < FULL);
      next_flags.tx_half    = (flg.level <= HALF);
      next_flags.tx_drained = (flg.level == '0);
    end
    else
    begin
      next_flags.rx_full    = (flg.level == FULL);
      next_flags.rx_half    = (flg.level >= HALF);
      next_flags.rx_pending = (flg.level != '0);
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      flg.flags <= '0;
    else
      flg.flags <= next_flags;
  end

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  a_tx_space_live: assert property (flg.transmit |=> flg.flags.tx_space == ($past(flg.level) < FULL))
    else $error("tx space flag does not follow level");
  a_tx_half_live: assert property (flg.transmit |=> flg.flags.tx_half == ($past(flg.level) <= HALF))
    else $error("tx half flag does not follow level");
  a_tx_drained_live: assert property (flg.transmit |=> flg.flags.tx_drained == ($past(flg.level) == '0))
    else $error("tx drained flag does not follow level");
  a_rx_full_live: assert property (!flg.transmit |=> flg.flags.rx_full == ($past(flg.level) == FULL))
    else $error("rx full flag does not follow level");
  a_rx_half_live: assert property (!flg.transmit |=> flg.flags.rx_half == ($past(flg.level) >= HALF))
    else $error("rx half flag does not follow level");
  a_rx_pending_live: assert property (!flg.transmit |=> flg.flags.rx_pending == ($past(flg.level) != '0))
    else $error("rx pending flag does not follow level");

endmodule

// File: core/cfi_flag_if.sv
// carrier between the register block and the flag evaluator
interface cfi_flag_if
  import cfi_pkg::*;
#(
  parameter int unsigned LVL_W = 6
);
  logic [LVL_W-1:0] level;
  logic             transmit;
  cfi_flags_s       flags;

  modport ctrl (output level, output transmit, input flags);
  modport eval (input level, input transmit, output flags);
endinterface

// File: core/cfi_pkg.sv
// types shared by the fifo interrupt block
package cfi_pkg;

  typedef enum logic [1:0]
  {
    CFI_IDLE = 2'b01,
    CFI_ACK  = 2'b10
  } cfi_bus_state_e;

  typedef struct packed
  {
    logic tx_space;
    logic tx_half;
    logic tx_drained;
    logic rx_full;
    logic rx_half;
    logic rx_pending;
  } cfi_flags_s;

endpackage

// File: core/cfi_top.sv
// fifo interrupt enable and status flag block with its register slave
// Behaviour
// - three tx enables at bits 26..24
// - four rx enables at bits 19..16
// - tx bit 10 high while space remains
// - tx bit 9 high at or below half
// - tx bit 8 high when fifo empty
// - receive mode: tx flags read zero
// - transmit mode: rx flags read zero
// - overflow in receive mode sets bit 3; software clears it
// - rx bit 2 high while fifo full
// - rx bit 1 high at half or more
// - rx bit 0 high while not empty
// - live flags ignore software writes
// - unused bits zero; enables, overflow reset zero
`include "cfi_defs.svh"
module cfi_top
  import cfi_pkg::*;
#(
  parameter int unsigned DEPTH = 32,
  parameter int unsigned LVL_W = $clog2(DEPTH + 1)
)
(
  input  wire logic              sys_clk_i,
  input  wire logic              arst_n_i,
  input  wire logic [4:0]        avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [31:0]       avs_writedata_i,
  input  wire logic [3:0]        avs_byteenable_i,
  output logic      [31:0]       avs_readdata_o,
  output logic                   avs_waitrequest_o,
  input  wire logic [LVL_W-1:0]  fill_level_i,
  input  wire logic              overflow_event_i,
  output logic                   fifo_irq_o,
  output logic                   irq_o
);

  // ----------------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------------
  cfi_bus_state_e   bus_state;
  cfi_bus_state_e   next_bus_state;
  logic [2:0]       tx_irq_en;
  logic [3:0]       rx_irq_en;
  logic             rx_overrun_flag;
  logic             fifo_direction_transmit;
  logic [31:0]      evt_status;
  logic [31:0]      evt_enable;
  logic [31:0]      flag_prev;
  logic [31:0]      ctrl_view;
  logic [31:0]      flag_vec;
  logic [31:0]      evt_set;
  logic [31:0]      evt_clr;
  logic [31:0]      next_rdata;
  logic [31:0]      be_mask;
  logic             req;
  logic             wr_take;
  logic             ovf_clear;
  logic             ovf_set;

  cfi_flag_if #(.LVL_W(LVL_W)) flg ();

  cfi_flag_eval #(
    .DEPTH (DEPTH),
    .LVL_W (LVL_W)
  ) u_eval (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .flg       (flg)
  );

  assign flg.level    = fill_level_i;
  assign flg.transmit = fifo_direction_transmit;

  // ----------------------------------------------------------------------------
  // register bus handshake
  // ----------------------------------------------------------------------------
  // every access costs one wait cycle; read data is captured in that cycle so
  // the master sees a stable word at the edge where waitrequest drops
  assign req               = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & (bus_state != CFI_ACK);
  assign wr_take           = avs_write_i & (bus_state == CFI_ACK);

  always_comb
  begin
    case (bus_state)
      CFI_IDLE:
        next_bus_state = req ? CFI_ACK : CFI_IDLE;
      CFI_ACK:
        next_bus_state = CFI_IDLE;
      default:
        next_bus_state = CFI_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      bus_state <= CFI_IDLE;
    else
      bus_state <= next_bus_state;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_be
      assign be_mask[gi*8 +: 8] = {8{avs_byteenable_i[gi]}};
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // control and status word
  // ----------------------------------------------------------------------------
  // flags are masked here too, so a direction change never shows a stale flag
  assign ctrl_view = {5'h00, tx_irq_en, 4'h0, rx_irq_en,
                      5'h00,
                      {3{fifo_direction_transmit}} & {flg.flags.tx_space,
                      flg.flags.tx_half, flg.flags.tx_drained},
                      4'h0,
                      rx_overrun_flag & ~fifo_direction_transmit,
                      {3{~fifo_direction_transmit}} & {flg.flags.rx_full,
                      flg.flags.rx_half, flg.flags.rx_pending}};

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      tx_irq_en <= `CFI_TX_IE_RST;
    else if (wr_take && avs_address_i == `CFI_OFS_CTRL && avs_byteenable_i[3])
      tx_irq_en <= avs_writedata_i[`CFI_TX_IE_LSB +: 3];
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rx_irq_en <= `CFI_RX_IE_RST;
    else if (wr_take && avs_address_i == `CFI_OFS_CTRL && avs_byteenable_i[2])
      rx_irq_en <= avs_writedata_i[`CFI_RX_IE_LSB +: 4];
  end

  // writing a zero clears the overrun flag, writing a one leaves it alone;
  // an overrun arriving in the same cycle as the clear keeps the flag set
  assign ovf_clear = wr_take && avs_address_i == `CFI_OFS_CTRL && avs_byteenable_i[0]
                     && !avs_writedata_i[`CFI_OVF_POS];
  assign ovf_set   = overflow_event_i & ~fifo_direction_transmit;

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rx_overrun_flag <= `CFI_OVF_RST;
    else if (ovf_set)
      rx_overrun_flag <= 1'b1;
    else if (ovf_clear)
      rx_overrun_flag <= 1'b0;
  end

  // the live flags have no storage here, so bus writes cannot reach them

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      fifo_direction_transmit <= `CFI_DIR_RST;
    else if (wr_take && avs_address_i == `CFI_OFS_CFG && avs_byteenable_i[0])
      fifo_direction_transmit <= avs_writedata_i[`CFI_DIR_POS];
  end

  // ----------------------------------------------------------------------------
  // interrupt requests
  // ----------------------------------------------------------------------------
  // ctrl_view already holds zero for flags of the other direction, so only
  // applicable flags can raise the request
  assign fifo_irq_o = |({tx_irq_en, rx_irq_en} &
                        {ctrl_view[`CFI_TX_IF_LSB +: 3], ctrl_view[`CFI_RX_IF_LSB +: 4]});

  // sticky events fire on each rising flag; a direction change can raise some
  assign flag_vec = ctrl_view & `CFI_FLAG_MASK;
  assign evt_set  = flag_vec & ~flag_prev;
  assign evt_clr  = (wr_take && avs_address_i == `CFI_OFS_CLR)
                    ? (avs_writedata_i & be_mask) : `CFI_WORD_RST;

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      flag_prev <= `CFI_WORD_RST;
    else
      flag_prev <= flag_vec;
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      evt_status <= `CFI_WORD_RST;
    else
      evt_status <= ((evt_status & ~evt_clr) | evt_set) & `CFI_FLAG_MASK;
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      evt_enable <= `CFI_WORD_RST;
    else if (wr_take && avs_address_i == `CFI_OFS_IEN)
      evt_enable <= ((evt_enable & ~be_mask) | (avs_writedata_i & be_mask))
                    & `CFI_FLAG_MASK;
  end

  assign irq_o = |(evt_status & evt_enable);

  // ----------------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------------
  always_comb
  begin
    case (avs_address_i)
      `CFI_OFS_CTRL:
        next_rdata = ctrl_view;
      `CFI_OFS_CFG:
        next_rdata = {31'h0000_0000, fifo_direction_transmit};
      `CFI_OFS_EVT:
        next_rdata = evt_status;
      `CFI_OFS_IEN:
        next_rdata = evt_enable;
      default:
        next_rdata = `CFI_WORD_RST;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      avs_readdata_o <= `CFI_WORD_RST;
    else if (avs_read_i && bus_state == CFI_IDLE)
      avs_readdata_o <= next_rdata;
  end

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  a_tx_enable_write: assert property (
    wr_take && avs_address_i == `CFI_OFS_CTRL && avs_byteenable_i[3]
    |=> tx_irq_en == $past(avs_writedata_i[26:24]) && ctrl_view[26:24] == tx_irq_en)
    else $error("tx enables not written");

  a_rx_enable_write: assert property (
    wr_take && avs_address_i == `CFI_OFS_CTRL && avs_byteenable_i[2]
    |=> ctrl_view[19:16] == $past(avs_writedata_i[19:16]))
    else $error("rx enables not written");

  a_rx_mode_tx_zero: assert property (
    !fifo_direction_transmit && !$past(fifo_direction_transmit) |-> ctrl_view[10:8] == 3'h0)
    else $error("tx flags visible in receive mode");

  a_tx_mode_rx_zero: assert property (
    fifo_direction_transmit && $past(fifo_direction_transmit) |-> ctrl_view[3:0] == 4'h0)
    else $error("rx flags visible in transmit mode");

  a_overrun_set: assert property (
    ovf_set |=> rx_overrun_flag ##0 ctrl_view[3] == !fifo_direction_transmit)
    else $error("overrun event lost");

  a_overrun_clear: assert property (
    ovf_clear && !ovf_set |=> !rx_overrun_flag)
    else $error("overrun not cleared");

  a_unused_bits_zero: assert property (
    (ctrl_view & ~`CFI_IMPL_MASK) == 32'h0000_0000)
    else $error("unimplemented bits read nonzero");

  a_live_flag_write: assert property (
    wr_take && avs_address_i == `CFI_OFS_CTRL && $stable(fill_level_i) && $stable(flg.transmit)
    ##1 $stable(fill_level_i) |=> $stable(ctrl_view[10:8]) && $stable(ctrl_view[2:0]))
    else $error("bus write altered a live flag");

  a_irq_request: assert property (
    fifo_direction_transmit && tx_irq_en[0] && flg.flags.tx_drained |-> fifo_irq_o)
    else $error("enabled flag raised no request");

  a_irq_masked: assert property (
    tx_irq_en == 3'h0 && rx_irq_en == 4'h0 |-> !fifo_irq_o)
    else $error("request without any enable");

  a_wait_one_cycle: assert property (
    req && bus_state == CFI_IDLE |-> avs_waitrequest_o ##1 !avs_waitrequest_o || !req)
    else $error("bus answer not after one wait cycle");

  a_event_sticky: assert property (
    evt_set[0] |=> evt_status[0] ##1 (evt_status[0] || $past(evt_clr[0])))
    else $error("sticky event lost");

  // a set and a clear in one cycle must leave the bit set
  a_event_set_wins: assert property (
    evt_set[0] && evt_clr[0] |=> evt_status[0])
    else $error("event clear beat a new event");

  a_event_clear: assert property (
    evt_clr[0] && !evt_set[0] |=> !evt_status[0])
    else $error("event not cleared");

  a_overrun_set_wins: assert property (
    ovf_set && ovf_clear |=> rx_overrun_flag)
    else $error("overrun clear beat a new overrun");

  // in transmit mode nothing may set the overrun flag
  a_tx_overrun_ignored: assert property (
    fifo_direction_transmit && !rx_overrun_flag |=> !rx_overrun_flag)
    else $error("overrun set in transmit mode");

  // enables move only on a write to the control word
  a_enable_hold: assert property (
    !(wr_take && avs_address_i == `CFI_OFS_CTRL) |=> $stable(tx_irq_en) && $stable(rx_irq_en))
    else $error("enables changed without a write");

  a_direction_write: assert property (
    wr_take && avs_address_i == `CFI_OFS_CFG && avs_byteenable_i[0]
    |=> fifo_direction_transmit == $past(avs_writedata_i[`CFI_DIR_POS]))
    else $error("direction not written");

  // the word handed out in the answer cycle is the one captured a cycle before
  a_read_config_word: assert property (
    avs_read_i && bus_state == CFI_ACK && avs_address_i == `CFI_OFS_CFG && $past(avs_read_i)
    |-> avs_readdata_o == {31'h0000_0000, $past(fifo_direction_transmit)})
    else $error("config read data wrong");

  a_rx_overrun_request: assert property (
    !fifo_direction_transmit && rx_irq_en[3] && rx_overrun_flag |-> fifo_irq_o)
    else $error("enabled overrun raised no request");

  // a request must trace back to a flag of the current direction
  a_irq_applicable: assert property (
    fifo_irq_o |-> (fifo_direction_transmit ? |(tx_irq_en & ctrl_view[10:8])
                                             : |(rx_irq_en & ctrl_view[3:0])))
    else $error("request from a flag of the other direction");

  a_rx_full_half: assert property (
    flg.flags.rx_full |-> flg.flags.rx_half)
    else $error("full fifo not reported half full");

  a_tx_drained_space: assert property (
    flg.flags.tx_drained |-> flg.flags.tx_space && flg.flags.tx_half)
    else $error("empty fifo not reported with space");

  c_tx_irq: cover property (fifo_direction_transmit && fifo_irq_o);
  c_rx_overrun: cover property (ovf_set ##1 rx_overrun_flag ##[1:20] ovf_clear);
  c_event_irq: cover property (irq_o ##[1:20] !irq_o);
  c_rx_full_irq: cover property (!fifo_direction_transmit && rx_irq_en[2] && flg.flags.rx_full);
  c_status_read: cover property (avs_read_i && !avs_waitrequest_o
                                 && avs_address_i == `CFI_OFS_CTRL);

endmodule

// File: verification/cfi_occ_model.sv
// far-side occupancy source: queued message count and receive overrun pulses
module cfi_occ_model
#(
  parameter int unsigned LVL_W = 6
)
(
  input  wire logic             sys_clk_i,
  output logic      [LVL_W-1:0] fill_level_o,
  output logic                  overflow_event_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    fill_level_o     = '0;
    overflow_event_o = 1'b0;
  end

  // the count moves only just after an edge, like the real occupancy counters
  task automatic set_level(input int unsigned l);
    @(posedge sys_clk_i);
    fill_level_o <= LVL_W'(l);
  endtask

  // one high cycle is one overrun
  task automatic pulse_overflow();
    @(posedge sys_clk_i);
    overflow_event_o <= 1'b1;
    @(posedge sys_clk_i);
    overflow_event_o <= 1'b0;
  endtask
endmodule

// File: verification/testbench.sv
// self-checking bench for the fifo interrupt block
`include "cfi_defs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned DEPTH = 32;
  localparam int unsigned LVL_W = 6;
  localparam logic [31:0] EN_ALL = 32'h070f_0000;

  logic             sys_clk_i;
  logic             arst_n_i;
  logic [4:0]       addr;
  logic             rd;
  logic             wr;
  logic [31:0]      wdata;
  logic [3:0]       be;
  logic [31:0]      rdata;
  logic             wait_o;
  logic [LVL_W-1:0] lvl;
  logic             ovf_evt;
  logic             fifo_irq;
  logic             irq;
  logic [31:0]      rv;
  int               n_errors;
  int               n_checks;
  int               lv[6] = '{0, 1, 15, 16, 31, 32};

  cfi_top #(.DEPTH(DEPTH), .LVL_W(LVL_W)) u_dut
  (
    .sys_clk_i        (sys_clk_i),
    .arst_n_i         (arst_n_i),
    .avs_address_i    (addr),
    .avs_read_i       (rd),
    .avs_write_i      (wr),
    .avs_writedata_i  (wdata),
    .avs_byteenable_i (be),
    .avs_readdata_o   (rdata),
    .avs_waitrequest_o(wait_o),
    .fill_level_i     (lvl),
    .overflow_event_i (ovf_evt),
    .fifo_irq_o       (fifo_irq),
    .irq_o            (irq)
  );

  cfi_occ_model #(.LVL_W(LVL_W)) u_occ
  (
    .sys_clk_i       (sys_clk_i),
    .fill_level_o    (lvl),
    .overflow_event_o(ovf_evt)
  );

  initial
  begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  task automatic results();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // request held until waitrequest is sampled low; data taken at that edge only
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     input logic [3:0] b);
    int i;
    @(posedge sys_clk_i);
    addr  <= a;
    wdata <= d;
    be    <= b;
    rd    <= ~w;
    wr    <= w;
    for (i = 0; i < 20; i++)
    begin
      @(posedge sys_clk_i);
      if (wait_o === 1'b0)
        break;
    end
    rv = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (i == 20)
    begin
      n_errors++;
      results();
    end
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp, input string name);
    bus(1'b0, a, 32'h0000_0000, 4'hf);
    chk(name, rv, exp);
  endtask

  // flags follow the level one edge later; settle before looking
  task automatic lvl_set(input int unsigned l);
    u_occ.set_level(l);
    repeat (3) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
  endtask

  function automatic logic [31:0] exp_ctrl(input logic tx, input int l, input logic ov);
    logic [31:0] e;
    e = EN_ALL;
    if (tx)
      e[10:8] = {l < DEPTH, l <= DEPTH / 2, l == 0};
    else
      e[3:0] = {ov, l == DEPTH, l >= DEPTH / 2, l > 0};
    return e;
  endfunction

  initial
  begin
    repeat (20000) @(posedge sys_clk_i);
    n_errors++;
    results();
  end

  initial
  begin
    arst_n_i = 1'b0;
    addr     = 5'h00;
    rd       = 1'b0;
    wr       = 1'b0;
    wdata    = 32'h0000_0000;
    be       = 4'h0;
    n_errors = 0;
    n_checks = 0;
    repeat (4) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    rd_chk(`CFI_OFS_CTRL, 32'h0000_0000, "ctrl_reset");
    rd_chk(`CFI_OFS_CFG, 32'h0000_0000, "cfg_reset");
    rd_chk(`CFI_OFS_IEN, 32'h0000_0000, "ien_reset");
    // event path: raise, masked, enabled, cleared
    lvl_set(1);
    chk("irq_masked", irq, 1'b0);
    rd_chk(`CFI_OFS_EVT, 32'h0000_0001, "evt_pending");
    bus(1'b1, `CFI_OFS_IEN, 32'h0000_0001, 4'hf);
    @(negedge sys_clk_i);
    chk("irq_enabled", irq, 1'b1);
    bus(1'b1, `CFI_OFS_EVT, 32'h0000_0000, 4'hf);
    bus(1'b1, `CFI_OFS_CLR, 32'h0000_0001, 4'hf);
    @(negedge sys_clk_i);
    chk("irq_cleared", irq, 1'b0);
    rd_chk(`CFI_OFS_EVT, 32'h0000_0000, "evt_cleared");
    rd_chk(5'h14, 32'h0000_0000, "unmapped_read");
    lvl_set(0);
    // all ones: only enables stick, overflow write of one does nothing
    bus(1'b1, `CFI_OFS_CTRL, 32'hffff_ffff, 4'hf);
    rd_chk(`CFI_OFS_CTRL, EN_ALL, "ctrl_enables");
    chk("fifo_irq_idle", fifo_irq, 1'b0);
    foreach (lv[k])
    begin
      lvl_set(lv[k]);
      chk("fifo_irq_rx", fifo_irq, lv[k] != 0);
      rd_chk(`CFI_OFS_CTRL, exp_ctrl(1'b0, lv[k], 1'b0), "ctrl_rx");
    end
    bus(1'b1, `CFI_OFS_CTRL, 32'h0000_0000, 4'hf);
    @(negedge sys_clk_i);
    chk("fifo_irq_gated", fifo_irq, 1'b0);
    lvl_set(0);
    bus(1'b1, `CFI_OFS_CTRL, EN_ALL, 4'hf);
    u_occ.pulse_overflow();
    lvl_set(0);
    chk("fifo_irq_ovf", fifo_irq, 1'b1);
    rd_chk(`CFI_OFS_CTRL, exp_ctrl(1'b0, 0, 1'b1), "ovf_set");
    // lane 0 disabled: the clear must not land
    bus(1'b1, `CFI_OFS_CTRL, EN_ALL, 4'he);
    rd_chk(`CFI_OFS_CTRL, exp_ctrl(1'b0, 0, 1'b1), "ovf_lane");
    bus(1'b1, `CFI_OFS_CTRL, EN_ALL, 4'hf);
    rd_chk(`CFI_OFS_CTRL, exp_ctrl(1'b0, 0, 1'b0), "ovf_clear");
    // transmit direction: overrun ignored, a stored one and the rx side read zero
    u_occ.pulse_overflow();
    bus(1'b1, `CFI_OFS_CFG, 32'h0000_0001, 4'hf);
    rd_chk(`CFI_OFS_CFG, 32'h0000_0001, "cfg_tx");
    u_occ.pulse_overflow();
    foreach (lv[k])
    begin
      lvl_set(lv[k]);
      chk("fifo_irq_tx", fifo_irq, lv[k] != DEPTH);
      rd_chk(`CFI_OFS_CTRL, exp_ctrl(1'b1, lv[k], 1'b0), "ctrl_tx");
    end
    // back to receive: the overrun kept while transmitting shows again
    bus(1'b1, `CFI_OFS_CFG, 32'h0000_0000, 4'hf);
    rd_chk(`CFI_OFS_CTRL, exp_ctrl(1'b0, DEPTH, 1'b1), "ovf_kept");
    results();
  end
endmodule
